// ===== common/jtp_pkg.sv
// Purpose: Shared constants and types for the analog-scan test port
// Assumes: Test clock is sampled by a 20 MHz system clock
// Notes: Instruction codes and analog codes are the port's own encodings
package jtp_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int JTP_IR_W = 3;
	localparam int JTP_ASR_W = 5;
	localparam int JTP_ID_W = 32;
	localparam int JTP_NCH = 8;

	// ************************************************************
	// Instruction codes
	// ************************************************************
	localparam logic [2:0] JTP_INS_EXTEST = 3'h0;
	localparam logic [2:0] JTP_INS_ANALOG = 3'h2;
	localparam logic [2:0] JTP_INS_SAMPLE = 3'h4;
	localparam logic [2:0] JTP_INS_IDCODE = 3'h6;
	localparam logic [2:0] JTP_INS_BYPASS = 3'h7;
	localparam logic [2:0] JTP_IR_CAPTURE = 3'h1;

	// ************************************************************
	// Analog code fields
	// ************************************************************
	localparam int JTP_ASR_EN_BIT = 4;
	localparam int JTP_ASR_TX_BIT = 3;
	localparam logic [2:0] JTP_CH_MAX = 3'h7;

	// ************************************************************
	// Identification layout (values are arbitrary)
	// ************************************************************
	localparam logic [3:0] JTP_ID_REV = 4'h1;
	localparam logic [15:0] JTP_ID_PART = 16'h0a5c;
	localparam logic [10:0] JTP_ID_MAKER = 11'h02a;
	localparam logic JTP_ID_LSB = 1'b1;

	// ************************************************************
	// TAP states, one-hot
	// ************************************************************
	typedef enum logic [15:0] {
		JTP_RESET = 16'h0001, JTP_IDLE = 16'h0002, JTP_SEL_DR = 16'h0004,
		JTP_CAP_DR = 16'h0008, JTP_SH_DR = 16'h0010, JTP_EX1_DR = 16'h0020,
		JTP_PA_DR = 16'h0040, JTP_EX2_DR = 16'h0080, JTP_UP_DR = 16'h0100,
		JTP_SEL_IR = 16'h0200, JTP_CAP_IR = 16'h0400, JTP_SH_IR = 16'h0800,
		JTP_EX1_IR = 16'h1000, JTP_PA_IR = 16'h2000, JTP_EX2_IR = 16'h4000,
		JTP_UP_IR = 16'h8000
	} jtp_state_t;

	// Analog switch routing, one bit per channel in each field
	typedef struct packed {
		logic [7:0] force_tx_tip;
		logic [7:0] sense_tx_ring;
		logic [7:0] force_rx_tip;
		logic [7:0] sense_rx_ring;
	} jtp_analog_t;

endpackage : jtp_pkg

// ===== core/jtp_port.sv
// Purpose: Boundary-scan test port with analog port select register
// Assumes: tck_in much slower than clk_in (400 ns vs 50 ns); pins synchronised here
// Notes: Boundary chain length is a parameter; pin cells capture pin inputs, receive cells capture rx_tristate_out
// Contract
// - Five-bit analog select shift register
// - Analog instruction routes select register TDI-TDO
// - Five rising edges load a full code
// - Analog code shifts least significant first
// - Codes 11111..11000 route transmit pairs 0..7
// - Codes 10111..10000 route receive pairs 0..7
// - Identification fields revision, part, maker
// - Identification bit zero is one
// - Identification shifts least significant first
// - Single-bit passthrough from TDI to TDO
// - Three-bit instruction shift register
// - Instruction shifts least significant first
// - Code 000 selects chain, drives pins
// - Code 010 selects analog register, enables switches
// - Code 100 samples chain, normal paths kept
// - Code 110 selects identification register
// - Code 111 selects passthrough
// - TDO changes after falling test clock
// - Per-channel cell tristates receive outputs
`timescale 1ns/1ps
module jtp_port #(
	parameter int BSC_W = 24
) (
	// System
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Test pins
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_out,
	// Boundary chain pins
	input wire logic [BSC_W-1:0] pin_sample_in,
	input wire logic [BSC_W-1:0] core_drive_in,
	output logic [BSC_W-1:0] pin_drive_out,
	input wire logic [jtp_pkg::JTP_NCH-1:0] core_rx_tristate_in,
	output logic [jtp_pkg::JTP_NCH-1:0] rx_tristate_out,
	// Analog switches
	output jtp_pkg::jtp_analog_t analog_sw_out
);
	import jtp_pkg::*;

	// ************************************************************
	// Input synchronisers and test clock edges
	// ************************************************************
	logic [2:0] sync1_ff, sync2_ff;
	logic tck_d_ff;
	logic tck_rise, tck_fall;
	// Only the second stage is read, avoiding metastable decisions
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
			tck_d_ff <= 1'b0;
		end else begin
			sync1_ff <= {tck_in, tms_in, tdi_in};
			sync2_ff <= sync1_ff;
			tck_d_ff <= sync2_ff[2];
		end
	end
	assign tck_rise = sync2_ff[2] & ~tck_d_ff;
	assign tck_fall = ~sync2_ff[2] & tck_d_ff;
	wire tms_s = sync2_ff[1];
	wire tdi_s = sync2_ff[0];

	// Pin values are asynchronous to clk_in: two stages before capture
	logic [BSC_W-1:0] pin_meta_ff, pin_sync_ff;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
		end else begin
			pin_meta_ff <= pin_sample_in;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// ************************************************************
	// TAP controller
	// ************************************************************
	jtp_state_t state_ff, nxt_state;
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			JTP_RESET: nxt_state = tms_s ? JTP_RESET : JTP_IDLE;
			JTP_IDLE: nxt_state = tms_s ? JTP_SEL_DR : JTP_IDLE;
			JTP_SEL_DR: nxt_state = tms_s ? JTP_SEL_IR : JTP_CAP_DR;
			JTP_CAP_DR: nxt_state = tms_s ? JTP_EX1_DR : JTP_SH_DR;
			JTP_SH_DR: nxt_state = tms_s ? JTP_EX1_DR : JTP_SH_DR;
			JTP_EX1_DR: nxt_state = tms_s ? JTP_UP_DR : JTP_PA_DR;
			JTP_PA_DR: nxt_state = tms_s ? JTP_EX2_DR : JTP_PA_DR;
			JTP_EX2_DR: nxt_state = tms_s ? JTP_UP_DR : JTP_SH_DR;
			JTP_UP_DR: nxt_state = tms_s ? JTP_SEL_DR : JTP_IDLE;
			JTP_SEL_IR: nxt_state = tms_s ? JTP_RESET : JTP_CAP_IR;
			JTP_CAP_IR: nxt_state = tms_s ? JTP_EX1_IR : JTP_SH_IR;
			JTP_SH_IR: nxt_state = tms_s ? JTP_EX1_IR : JTP_SH_IR;
			JTP_EX1_IR: nxt_state = tms_s ? JTP_UP_IR : JTP_PA_IR;
			JTP_PA_IR: nxt_state = tms_s ? JTP_EX2_IR : JTP_PA_IR;
			JTP_EX2_IR: nxt_state = tms_s ? JTP_UP_IR : JTP_SH_IR;
			JTP_UP_IR: nxt_state = tms_s ? JTP_SEL_DR : JTP_IDLE;
			default: nxt_state = JTP_RESET;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_ff <= JTP_RESET;
		end else if (tck_rise) begin
			state_ff <= nxt_state;
		end
	end

	// ************************************************************
	// Instruction register and decode
	// ************************************************************
	logic [JTP_IR_W-1:0] ir_sh_ff, test_instruction_ff;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ir_sh_ff <= '0;
			test_instruction_ff <= JTP_INS_IDCODE;
		end else if (state_ff == JTP_RESET) begin
			test_instruction_ff <= JTP_INS_IDCODE;
		end else if (tck_rise) begin
			if (state_ff == JTP_CAP_IR)
				ir_sh_ff <= JTP_IR_CAPTURE;
			else if (state_ff == JTP_SH_IR)
				ir_sh_ff <= {tdi_s, ir_sh_ff[JTP_IR_W-1:1]};
		end else if (tck_fall && state_ff == JTP_UP_IR) begin
			test_instruction_ff <= ir_sh_ff;
		end
	end
	wire sel_bsc = (test_instruction_ff == JTP_INS_EXTEST) ||
		(test_instruction_ff == JTP_INS_SAMPLE);
	wire sel_asr = (test_instruction_ff == JTP_INS_ANALOG);
	wire sel_id = (test_instruction_ff == JTP_INS_IDCODE);
	wire sel_byp = !(sel_bsc || sel_asr || sel_id);
	wire extest = (test_instruction_ff == JTP_INS_EXTEST);

	// ************************************************************
	// Data registers: shift on rising test clock
	// ************************************************************
	localparam logic [JTP_ID_W-1:0] ID_VALUE = {JTP_ID_REV, JTP_ID_PART,
		JTP_ID_MAKER, JTP_ID_LSB};
	logic [JTP_ASR_W-1:0] asr_sh_ff, analog_port_select_ff;
	logic [JTP_ID_W-1:0] id_sh_ff;
	logic single_bit_passthrough_ff;
	logic [BSC_W+JTP_NCH-1:0] bsc_sh_ff, bsc_upd_ff;
	wire dr_rise = tck_rise && (state_ff == JTP_SH_DR);
	wire cap_rise = tck_rise && (state_ff == JTP_CAP_DR);
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			asr_sh_ff <= '0;
			id_sh_ff <= '0;
			single_bit_passthrough_ff <= 1'b0;
			bsc_sh_ff <= '0;
		end else if (cap_rise) begin
			id_sh_ff <= ID_VALUE;
			single_bit_passthrough_ff <= 1'b0;
			asr_sh_ff <= analog_port_select_ff;
			bsc_sh_ff <= {rx_tristate_out, pin_sync_ff};
		end else if (dr_rise) begin
			if (sel_asr)
				asr_sh_ff <= {tdi_s, asr_sh_ff[JTP_ASR_W-1:1]};
			if (sel_id)
				id_sh_ff <= {tdi_s, id_sh_ff[JTP_ID_W-1:1]};
			if (sel_byp)
				single_bit_passthrough_ff <= tdi_s;
			if (sel_bsc)
				bsc_sh_ff <= {tdi_s, bsc_sh_ff[BSC_W+JTP_NCH-1:1]};
		end
	end

	// Update stage: change only on update or in TAP reset (cleared) so pins do not ripple while shifting
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || state_ff == JTP_RESET) begin
			analog_port_select_ff <= '0;
			bsc_upd_ff <= '0;
		end else if (tck_fall && state_ff == JTP_UP_DR) begin
			if (sel_asr)
				analog_port_select_ff <= asr_sh_ff;
			if (sel_bsc)
				bsc_upd_ff <= bsc_sh_ff;
		end
	end

	// ************************************************************
	// Pin muxing
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_drive_out <= '0;
			rx_tristate_out <= '0;
		end else if (extest) begin
			pin_drive_out <= bsc_upd_ff[BSC_W-1:0];
			rx_tristate_out <= bsc_upd_ff[BSC_W+JTP_NCH-1:BSC_W];
		end else begin
			pin_drive_out <= core_drive_in;
			rx_tristate_out <= core_rx_tristate_in;
		end
	end

	// Channel index is inverted: code low bits 111 mean channel 0
	logic [2:0] ch;
	assign ch = JTP_CH_MAX - analog_port_select_ff[2:0];
	// Registered so switches never glitch while the code settles
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			analog_sw_out <= '0;
		end else begin
			analog_sw_out <= '0;
			if (sel_asr && analog_port_select_ff[JTP_ASR_EN_BIT]) begin
				if (analog_port_select_ff[JTP_ASR_TX_BIT]) begin
					analog_sw_out.force_tx_tip[ch] <= 1'b1;
					analog_sw_out.sense_tx_ring[ch] <= 1'b1;
				end else begin
					analog_sw_out.force_rx_tip[ch] <= 1'b1;
					analog_sw_out.sense_rx_ring[ch] <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Test data output, falling test clock
	// ************************************************************
	logic tdo_bit;
	always_comb begin
		tdo_bit = single_bit_passthrough_ff;
		if (state_ff == JTP_SH_IR)
			tdo_bit = ir_sh_ff[0];
		else if (sel_asr)
			tdo_bit = asr_sh_ff[0];
		else if (sel_id)
			tdo_bit = id_sh_ff[0];
		else if (sel_bsc)
			tdo_bit = bsc_sh_ff[0];
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			tdo_out <= 1'b0;
			tdo_oe_out <= 1'b0;
		end else if (tck_fall) begin
			tdo_out <= tdo_bit;
			tdo_oe_out <= (state_ff == JTP_SH_DR) || (state_ff == JTP_SH_IR);
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	tdo_fall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!tck_fall |=> $stable(tdo_out)) else $error("tdo moved off falling edge");
	asr_shift_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dr_rise && sel_asr |=> asr_sh_ff[JTP_ASR_W-1] == $past(tdi_s))
		else $error("analog shift wrong");
	asr_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!analog_port_select_ff[JTP_ASR_EN_BIT] |=> analog_sw_out == '0)
		else $error("switch closed with top bit clear");
	asr_tx0_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sel_asr && analog_port_select_ff == 5'h1f |=> analog_sw_out.force_tx_tip[0]
		&& analog_sw_out.sense_tx_ring[0]) else $error("code 11111 routing");
	asr_rx7_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sel_asr && analog_port_select_ff == 5'h10 |=> analog_sw_out.force_rx_tip[7]
		&& analog_sw_out.sense_rx_ring[7]) else $error("code 10000 routing");
	id_cap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		cap_rise |=> id_sh_ff == ID_VALUE && id_sh_ff[0]) else $error("id capture");
	byp_path_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dr_rise && sel_byp |=> single_bit_passthrough_ff == $past(tdi_s))
		else $error("bypass path");
	ir_decode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dr_rise && test_instruction_ff inside {3'h1, 3'h3, 3'h5}
		|=> single_bit_passthrough_ff == $past(tdi_s))
		else $error("unlisted code not bypass");
	ir_update_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tck_fall && state_ff == JTP_UP_IR |=> test_instruction_ff == $past(ir_sh_ff))
		else $error("instruction update");
	ir_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_ff == JTP_RESET |=> test_instruction_ff == JTP_INS_IDCODE)
		else $error("reset instruction");
	asr_update_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tck_fall && state_ff == JTP_UP_DR && sel_asr
		|=> analog_port_select_ff == $past(asr_sh_ff))
		else $error("analog update");
	id_shift_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dr_rise && sel_id |=> id_sh_ff[JTP_ID_W-1] == $past(tdi_s))
		else $error("id shift");
	sw_pair_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$countones(analog_sw_out) inside {0, 2})
		else $error("more than one pair closed");
	rx_extest_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		extest |=> rx_tristate_out == $past(bsc_upd_ff[BSC_W+JTP_NCH-1:BSC_W]))
		else $error("receive tristate cells");
	pin_sample_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!extest |=> pin_drive_out == $past(core_drive_in))
		else $error("normal path lost");
	bsc_update_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tck_fall && state_ff == JTP_UP_DR && sel_bsc |=> bsc_upd_ff == $past(bsc_sh_ff))
		else $error("chain update");
	tdo_oe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tck_fall && state_ff != JTP_SH_DR && state_ff != JTP_SH_IR |=> !tdo_oe_out)
		else $error("tdo driven outside shift");

	// Per-channel routing: one check for every line pair
	for (genvar g = 0; g < JTP_NCH; g++) begin : g_asr_chk
		localparam logic [2:0] LOW = JTP_CH_MAX - 3'(g);
		asr_tx_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
			sel_asr && analog_port_select_ff == {1'b1, 1'b1, LOW}
			|=> analog_sw_out.force_tx_tip[g] && analog_sw_out.sense_tx_ring[g])
			else $error("transmit pair routing");
		asr_rx_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
			sel_asr && analog_port_select_ff == {1'b1, 1'b0, LOW}
			|=> analog_sw_out.force_rx_tip[g] && analog_sw_out.sense_rx_ring[g])
			else $error("receive pair routing");
	end

	// Main scenarios seen
	ir_shift_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tck_rise && state_ff == JTP_SH_IR |=> ir_sh_ff[JTP_IR_W-1] == $past(tdi_s))
		else $error("ir shift");
	pin_extest_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		extest |=> pin_drive_out == $past(bsc_upd_ff[BSC_W-1:0]))
		else $error("extest drive");
	analog_cov: cover property (@(posedge clk_in) sel_asr && analog_port_select_ff[4]);
	id_cov: cover property (@(posedge clk_in) dr_rise && sel_id);
	extest_cov: cover property (@(posedge clk_in) extest && tck_fall && state_ff == JTP_UP_DR);
	bypass_cov: cover property (@(posedge clk_in) dr_rise && sel_byp);
	ir_cov: cover property (@(posedge clk_in) tck_fall && state_ff == JTP_UP_IR);

endmodule : jtp_port

// ===== sim/jtp_ctrl.sv
// Purpose: Test controller model for the scan port
// Assumes: 50 ns system clock, 400 ns test clock
// Notes: Test clock stops between ticks; idle data toggles
`timescale 1ns/1ps
module jtp_ctrl (
	// Clock
	input wire logic clk_in,
	// Scan pins
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in
);
	// ************************************************************
	// Ticks and scans
	// ************************************************************
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end

	// Low 5 clocks, high 3; data moves only at the fall
	task automatic tick(input logic ms, input logic di, output logic do_bit);
		@(posedge clk_in);
		tck_out <= 1'b0;
		tms_out <= ms;
		tdi_out <= di;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		do_bit = tdo_in; // Late in low phase, after the update
		@(posedge clk_in);
		tck_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask : tick

	// Five ones reach reset from any state
	task automatic reset_tap();
		logic b;
		repeat (5) tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
	endtask : reset_tap

	// From idle: one scan of n bits, least significant first
	task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, ~tdi_out, b);
		if (is_ir) tick(1'b1, ~tdi_out, b);
		tick(1'b0, ~tdi_out, b);
		tick(1'b0, ~tdi_out, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, ~tdi_out, b);
		tick(1'b0, ~tdi_out, b); // Update lands at this fall
	endtask : scan
endmodule : jtp_ctrl

// ===== sim/tb_jtp_port.sv
// Purpose: Self-checking bench for the scan port
// Assumes: Chain width 8, so chain is 16 cells
// Notes: Random data from a fixed LFSR seed
`timescale 1ns/1ps
module tb_jtp_port;
	import jtp_pkg::*;
	localparam int BW = 8;
	logic clk_in, rst_n_in, tck, tms, tdi, tdo, tdo_q, tdo_oe;
	logic [BW-1:0] pin_s, core_d, pin_d;
	logic [7:0] core_rx, rx_ts;
	logic [63:0] din, dout;
	logic [15:0] rnd = 16'h0055;
	logic [4:0] last5;
	jtp_analog_t sw;
	int miscompares = 0;
	int tests_run = 0;

	// ************************************************************
	// Harness
	// ************************************************************
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	jtp_port #(.BSC_W(BW)) jtp_port_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
		.pin_sample_in(pin_s), .core_drive_in(core_d), .pin_drive_out(pin_d),
		.core_rx_tristate_in(core_rx), .rx_tristate_out(rx_ts), .analog_sw_out(sw));
	jtp_ctrl jtp_ctrl_i (.clk_in(clk_in), .tck_out(tck), .tms_out(tms),
		.tdi_out(tdi), .tdo_in(tdo));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic rand64(output logic [63:0] r);
		for (int i = 0; i < 4; i++) begin
			rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
			r[i*16 +: 16] = rnd;
		end
	endtask : rand64

	// Scan path length per instruction; unlisted codes bypass
	function automatic int reg_len(input logic [2:0] c);
		case (c)
			JTP_INS_EXTEST, JTP_INS_SAMPLE: return BW + 8;
			JTP_INS_ANALOG: return JTP_ASR_W;
			JTP_INS_IDCODE: return JTP_ID_W;
			default: return 1;
		endcase
	endfunction : reg_len

	// Expected switch set for one analog code
	function automatic jtp_analog_t sw_exp(input logic [4:0] c);
		jtp_analog_t s;
		s = '0;
		if (c[4] && c[3]) begin
			s.force_tx_tip[3'h7 - c[2:0]] = 1'b1;
			s.sense_tx_ring[3'h7 - c[2:0]] = 1'b1;
		end else if (c[4]) begin
			s.force_rx_tip[3'h7 - c[2:0]] = 1'b1;
			s.sense_rx_ring[3'h7 - c[2:0]] = 1'b1;
		end
		return s;
	endfunction : sw_exp

	// Output may move only while the test clock is low
	always @(posedge clk_in) begin
		tdo_q <= tdo;
		if (rst_n_in && tck && tdo_q !== tdo) chk("tdo_edge", 64'(tdo_q), 64'(tdo));
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_in);
		miscompares++;
		test_done();
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		rst_n_in = 1'b0;
		pin_s = '0;
		core_d = '0;
		core_rx = '0;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		jtp_ctrl_i.reset_tap();
		chk("sw_reset", 64'h0, 64'(sw));
		chk("tdo_oe_idle", 64'h0, 64'(tdo_oe));
		jtp_ctrl_i.scan(1'b0, 32, 64'h0, dout);
		chk("tdo_oe_done", 64'h0, 64'(tdo_oe));
		chk("idcode", 64'({JTP_ID_REV, JTP_ID_PART, JTP_ID_MAKER, JTP_ID_LSB}),
			64'(dout[31:0]));
		// Every instruction code, random data through its path
		for (int c = 0; c < 8; c++) begin
			rand64(din);
			pin_s <= din[7:0];
			core_d <= din[15:8];
			core_rx <= din[23:16];
			jtp_ctrl_i.scan(1'b1, 3, 64'(c), dout);
			chk("ir_cap", 64'(JTP_IR_CAPTURE), dout);
			jtp_ctrl_i.scan(1'b0, 48, din, dout);
			chk("dr_path", ((64'h1 << (48 - reg_len(c))) - 64'h1) & din,
				64'(dout[47:0]) >> reg_len(c));
			if (c == 0 || c == 4) chk("capture", 64'(pin_s), 64'(dout[7:0]));
			if (c == 2) last5 = din[47:43];
			repeat (3) @(posedge clk_in);
			chk("pins", (c == 0) ? 64'(din[39:32]) : 64'(core_d), 64'(pin_d));
			chk("rx_hiz", (c == 0) ? 64'(din[47:40]) : 64'(core_rx), 64'(rx_ts));
			chk("sw", (c == 2) ? 64'(sw_exp(din[47:43])) : 64'h0, 64'(sw));
		end
		// All 32 analog codes, each but the last captured back on the next scan
		jtp_ctrl_i.scan(1'b1, 3, 64'(JTP_INS_ANALOG), dout);
		for (int k = 0; k < 32; k++) begin
			jtp_ctrl_i.scan(1'b0, 5, 64'(k), dout);
			chk("asr_cap", 64'(last5), dout);
			last5 = 5'(k);
			repeat (3) @(posedge clk_in);
			chk("switch", 64'(sw_exp(5'(k))), 64'(sw));
		end
		jtp_ctrl_i.scan(1'b1, 3, 64'(JTP_INS_BYPASS), dout);
		repeat (3) @(posedge clk_in);
		chk("sw_leave", 64'h0, 64'(sw));
		test_done();
	end
endmodule : tb_jtp_port
